// ---- verilog/dhpm_top.v ----
// Purpose: Hardware protection supervisor of a motor drive.
// Assumes: Measurements come from logic on clk_sys; run_cmd comes from a pin.
// Notes: Settings are captured on cfg_load and clamped to their ranges.
// How it works
// - Pre-alarm level 50 to 130 degrees, 95 after reset.
// - Any thermistor above level applies ramp, coast, fast stop, alarm or reduce.
// - Reduce mode keeps running, lowering speed by percent of maximum frequency.
// - Output function 20 closes whenever heatsink is above the pre-alarm level.
// - After 12 s, track bus minimum and maximum every 1.28 s window.
// - Ten-scan ripple sum above level times 400 or 800 trips phase loss.
// - Phase loss level 0.0 to 25.0 percent.
// - Enabled ground current above half rated current flags fault and coasts.
// - Ground current is the sum of the three phase currents.
// - Fan mode 0 runs fan with run; mode 1 keeps fan always on.
// - In run mode fan stays on 0 to 300 s after run drops.
// - Ambient 45 to 60 degrees; above 45 derates overload level.
// - Enabled low-speed option speeds overload build-up at 6 Hz and below.
// - Enabled soft limit lowers frequency above 110 percent current.
// - Hunting prevention trims voltage with gain 0.00 to 2.50, default 1.00.
// - Braking resistor selection is stored only.
`timescale 1ns/10ps
`include "dhpm_consts.vh"
module dhpm_top #(
    parameter P_TICK_CYC = `DHPM_TICK_CYC,
    parameter P_PL_START_MS = `DHPM_PL_START_MS,
    parameter P_PL_WIN_MS = `DHPM_PL_WIN_MS
) (
    // Clock and reset.
    input wire clk_sys,
    input wire sys_rst,
    // Settings, captured on cfg_load.
    input wire cfg_load,
    input wire braking_resistor_protect_sel,
    input wire [7:0] overheat_prealarm_level,
    input wire [2:0] overheat_action_sel,
    input wire [9:0] overheat_speed_reduction,
    input wire [7:0] phase_loss_level,
    input wire volt_class_400,
    input wire ground_fault_enable,
    input wire fan_mode_sel,
    input wire [8:0] fan_off_delay,
    input wire [5:0] ambient_temp_setting,
    input wire low_speed_overload_sel,
    input wire soft_current_limit_enable,
    input wire antihunt_enable,
    input wire [7:0] antihunt_gain,
    input wire [7:0] digital_output_function_sel,
    input wire [15:0] max_output_frequency,
    // Measurements.
    input wire run_cmd,
    input wire fault_reset,
    input wire [7:0] heatsink_temp_a,
    input wire [7:0] heatsink_temp_b,
    input wire [7:0] heatsink_temp_c,
    input wire bus_valid,
    input wire [11:0] dc_bus_volt,
    input wire signed [15:0] phase_cur_u,
    input wire signed [15:0] phase_cur_v,
    input wire signed [15:0] phase_cur_w,
    input wire [15:0] rated_current,
    input wire [15:0] output_frequency,
    input wire [15:0] speed_command,
    input wire signed [15:0] magnetising_current,
    // Actions and indications.
    output reg ramp_stop_req,
    output reg coast_stop_req,
    output reg fast_stop_req,
    output reg heatsink_overheat_fault,
    output reg heatsink_overheat_alarm,
    output reg digital_output,
    output reg [15:0] speed_command_limited,
    output reg software_current_limit,
    output reg input_phase_loss_fault,
    output reg ground_fault_indication,
    output reg drive_overload_fault,
    output reg fan_on,
    output reg signed [15:0] voltage_trim,
    output reg brake_sel_stored
);
    // ********
    // Helpers
    // ********
    // Clamp a setting into its legal range.
    function [7:0] dhpm_clamp;
        input [7:0] v;
        input [7:0] lo;
        input [7:0] hi;
        begin
            dhpm_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
        end
    endfunction

    // Magnitude of a signed value.
    function [16:0] dhpm_abs;
        input signed [16:0] v;
        begin
            dhpm_abs = v[16] ? -v : v;
        end
    endfunction

    // ********
    // Settings
    // ********
    reg [7:0] oh_level;
    reg [2:0] oh_action;
    reg [9:0] oh_reduce;
    reg [7:0] pl_level;
    reg class_400;
    reg gf_en;
    reg fan_mode;
    reg [8:0] fan_delay;
    reg [5:0] ambient;
    reg ls_ol_en;
    reg scla_en;
    reg hunt_en;
    reg [7:0] hunt_gain;
    reg [7:0] do_sel;
    reg [15:0] fmax;
    wire [7:0] amb_clamped = dhpm_clamp({2'b00, ambient_temp_setting}, {2'b00, `DHPM_AMB_MIN},
        {2'b00, `DHPM_AMB_MAX});

    // Settings are clamped on capture so an out-of-range value never acts.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            oh_level <= `DHPM_OH_LVL_DEF;
            oh_action <= `DHPM_ACT_REDUCE;
            oh_reduce <= `DHPM_RED_DEF;
            pl_level <= `DHPM_PL_DEF;
            class_400 <= 1'b0;
            gf_en <= 1'b1;
            fan_mode <= 1'b0;
            fan_delay <= `DHPM_FAN_DLY_DEF;
            ambient <= `DHPM_AMB_DEF;
            ls_ol_en <= 1'b1;
            scla_en <= 1'b1;
            hunt_en <= 1'b1;
            hunt_gain <= `DHPM_HUNT_GAIN_DEF;
            do_sel <= 8'h00;
            fmax <= 16'h0000;
            brake_sel_stored <= 1'b0;
        end else if (cfg_load) begin
            oh_level <= dhpm_clamp(overheat_prealarm_level, `DHPM_OH_LVL_MIN,
                `DHPM_OH_LVL_MAX);
            oh_action <= (overheat_action_sel > `DHPM_ACT_REDUCE) ?
                `DHPM_ACT_REDUCE : overheat_action_sel;
            oh_reduce <= (overheat_speed_reduction > `DHPM_RED_MAX) ?
                `DHPM_RED_MAX : overheat_speed_reduction;
            pl_level <= (phase_loss_level > `DHPM_PL_MAX) ?
                `DHPM_PL_MAX : phase_loss_level;
            class_400 <= volt_class_400;
            gf_en <= ground_fault_enable;
            fan_mode <= fan_mode_sel;
            fan_delay <= (fan_off_delay > `DHPM_FAN_DLY_MAX) ?
                `DHPM_FAN_DLY_MAX : fan_off_delay;
            ambient <= amb_clamped[5:0];
            ls_ol_en <= low_speed_overload_sel;
            scla_en <= soft_current_limit_enable;
            hunt_en <= antihunt_enable;
            hunt_gain <= (antihunt_gain > `DHPM_HUNT_GAIN_MAX) ?
                `DHPM_HUNT_GAIN_MAX : antihunt_gain;
            do_sel <= digital_output_function_sel;
            fmax <= max_output_frequency;
            brake_sel_stored <= braking_resistor_protect_sel;
        end
    end

    // ********
    // Run input synchroniser and time base
    // ********
    reg [2:0] run_sync;
    reg run;
    reg [31:0] tick_cnt;
    reg tick_ms;
    reg [9:0] ms_cnt;
    reg tick_s;

    // The run pin is only believed once two late stages agree.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            run_sync <= 3'h0;
            run <= 1'b0;
            tick_cnt <= 32'h00000000;
            tick_ms <= 1'b0;
            ms_cnt <= 10'h000;
            tick_s <= 1'b0;
        end else begin
            run_sync <= {run_sync[1:0], run_cmd};
            if (run_sync[2] == run_sync[1]) begin
                run <= run_sync[2];
            end
            tick_ms <= (tick_cnt == P_TICK_CYC - 1);
            tick_cnt <= (tick_cnt == P_TICK_CYC - 1) ? 32'h00000000 : tick_cnt + 32'h1;
            tick_s <= 1'b0;
            if (tick_ms) begin
                tick_s <= (ms_cnt == `DHPM_MS_PER_S - 10'd1);
                ms_cnt <= (ms_cnt == `DHPM_MS_PER_S - 10'd1) ? 10'h000 : ms_cnt + 10'h001;
            end
        end
    end

    // ********
    // Heatsink overheat
    // ********
    wire hot = (heatsink_temp_a > oh_level) || (heatsink_temp_b > oh_level) ||
        (heatsink_temp_c > oh_level);
    wire [25:0] red_prod = fmax * oh_reduce;
    wire [25:0] red_q = red_prod / 26'd1000;
    wire [15:0] red_amt = red_q[15:0];

    // Faulting actions latch until reset by fault_reset; a new hot reading wins.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            heatsink_overheat_fault <= 1'b0;
            heatsink_overheat_alarm <= 1'b0;
            ramp_stop_req <= 1'b0;
            fast_stop_req <= 1'b0;
            digital_output <= 1'b0;
        end else begin
            if (hot && oh_action <= `DHPM_ACT_FAST) begin
                heatsink_overheat_fault <= 1'b1;
                ramp_stop_req <= (oh_action == `DHPM_ACT_RAMP);
                fast_stop_req <= (oh_action == `DHPM_ACT_FAST);
            end else if (fault_reset) begin
                heatsink_overheat_fault <= 1'b0;
                ramp_stop_req <= 1'b0;
                fast_stop_req <= 1'b0;
            end
            heatsink_overheat_alarm <= hot && oh_action >= `DHPM_ACT_ALARM;
            digital_output <= hot && do_sel == `DHPM_DO_OH_PREALARM;
        end
    end

    // ********
    // Ground fault, soft current limit and speed command
    // ********
    wire [16:0] gnd_cur = dhpm_abs({phase_cur_u[15], phase_cur_u} +
        {phase_cur_v[15], phase_cur_v} + {phase_cur_w[15], phase_cur_w});
    wire [16:0] abs_u = dhpm_abs({phase_cur_u[15], phase_cur_u});
    wire [16:0] abs_v = dhpm_abs({phase_cur_v[15], phase_cur_v});
    wire [16:0] abs_w = dhpm_abs({phase_cur_w[15], phase_cur_w});
    wire [16:0] i_pk = (abs_u > abs_v) ? ((abs_u > abs_w) ? abs_u : abs_w) :
        ((abs_v > abs_w) ? abs_v : abs_w);
    wire [31:0] scla_lvl = rated_current * `DHPM_SCLA_PCT;
    wire over_scla = ({8'h00, i_pk} * 24'd100) > {1'b0, scla_lvl[23:0]};
    wire gf_hit = gf_en && ({gnd_cur, 1'b0} > {2'b00, rated_current});
    wire [15:0] after_oh = (hot && oh_action == `DHPM_ACT_REDUCE) ?
        ((speed_command > red_amt) ? speed_command - red_amt : 16'h0000) : speed_command;
    wire [15:0] after_cla = (output_frequency > `DHPM_SCLA_STEP) ?
        output_frequency - `DHPM_SCLA_STEP : 16'h0000;

    // Ground faults coast the drive; the soft limit releases as soon as current drops.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ground_fault_indication <= 1'b0;
            coast_stop_req <= 1'b0;
            software_current_limit <= 1'b0;
            speed_command_limited <= 16'h0000;
        end else begin
            if (gf_hit) begin
                ground_fault_indication <= 1'b1;
            end else if (fault_reset) begin
                ground_fault_indication <= 1'b0;
            end
            if (gf_hit || (hot && oh_action == `DHPM_ACT_COAST)) begin
                coast_stop_req <= 1'b1;
            end else if (fault_reset) begin
                coast_stop_req <= 1'b0;
            end
            software_current_limit <= scla_en && over_scla;
            if (scla_en && over_scla && after_cla < after_oh) begin
                speed_command_limited <= after_cla;
            end else begin
                speed_command_limited <= after_oh;
            end
        end
    end

    // ********
    // Drive overload
    // ********
    reg [23:0] ol_acc;
    wire [23:0] ol_lvl = `DHPM_OL2_BASE -
        ({18'h00000, ambient - `DHPM_AMB_MIN} * `DHPM_OL2_DERATE);
    wire slow = ls_ol_en && output_frequency <= `DHPM_LOW_SPEED_FREQ;
    wire [23:0] ol_w = slow ? `DHPM_OL2_FAST_W : 24'h000001;

    // Heat is integrated per millisecond above rated current and bleeds off below it.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ol_acc <= 24'h000000;
            drive_overload_fault <= 1'b0;
        end else begin
            if (tick_ms && i_pk > {1'b0, rated_current}) begin
                ol_acc <= ol_acc + ol_w;
            end else if (tick_ms && ol_acc != 24'h000000) begin
                ol_acc <= ol_acc - 24'h000001;
            end
            if (ol_acc >= ol_lvl) begin
                drive_overload_fault <= 1'b1;
            end else if (fault_reset) begin
                drive_overload_fault <= 1'b0;
            end
        end
    end

    // ********
    // Input phase loss
    // ********
    wire pl_trip;
    wire [17:0] pl_trip_sum = pl_level * (class_400 ? `DHPM_PL_K400 : `DHPM_PL_K200);

    dhpm_ripple #(
        .START_MS(P_PL_START_MS),
        .WIN_MS(P_PL_WIN_MS)
    ) u_ripple (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick_ms(tick_ms),
        .bus_valid(bus_valid),
        .bus_volt(dc_bus_volt),
        .trip_sum(pl_trip_sum),
        .trip(pl_trip)
    );

    // The phase loss trip latches until fault_reset; it raises no coast or other stop request.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            input_phase_loss_fault <= 1'b0;
        end else if (pl_trip) begin
            input_phase_loss_fault <= 1'b1;
        end else if (fault_reset) begin
            input_phase_loss_fault <= 1'b0;
        end
    end

    // ********
    // Fan and hunting prevention
    // ********
    wire fan_drive;
    reg signed [15:0] id_filt;
    wire signed [16:0] id_dev = magnetising_current - id_filt;
    wire signed [25:0] hunt_prod = id_dev * $signed({1'b0, hunt_gain});
    wire signed [25:0] hunt_q = -(hunt_prod / 26'sd100);

    dhpm_fan u_fan (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .tick_s(tick_s),
        .run(run),
        .fan_mode_sel(fan_mode),
        .fan_off_delay(fan_delay),
        .fan_on(fan_drive)
    );

    // A slow filter tracks the magnetising current; the trim opposes deviation.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            id_filt <= 16'sh0000;
            voltage_trim <= 16'sh0000;
            fan_on <= 1'b0;
        end else begin
            fan_on <= fan_drive;
            if (tick_ms) begin
                id_filt <= id_filt + {{3{id_dev[16]}}, id_dev[16:4]};
            end
            voltage_trim <= hunt_en ? hunt_q[15:0] : 16'sh0000;
        end
    end
endmodule // dhpm_top

// ---- verilog/dhpm_consts.vh ----
// Purpose: Shared constants of the drive hardware protection monitor.
// Assumes: Included by bare name from every design file.
// Notes: Definitions only.
`ifndef DHPM_CONSTS_VH
`define DHPM_CONSTS_VH
// ********
// Timing
// ********
`define DHPM_CLK_PERIOD_NS 10
`define DHPM_TICK_NS 1000000
`define DHPM_TICK_CYC (`DHPM_TICK_NS / `DHPM_CLK_PERIOD_NS)
`define DHPM_PL_START_MS 12000
`define DHPM_PL_WIN_MS 1280
`define DHPM_MS_PER_S 10'd1000
`define DHPM_PL_SCANS 4'd10
// ********
// Setting ranges and factory defaults
// ********
`define DHPM_OH_LVL_MIN 8'd50
`define DHPM_OH_LVL_MAX 8'd130
`define DHPM_OH_LVL_DEF 8'd95
`define DHPM_ACT_RAMP 3'd0
`define DHPM_ACT_COAST 3'd1
`define DHPM_ACT_FAST 3'd2
`define DHPM_ACT_ALARM 3'd3
`define DHPM_ACT_REDUCE 3'd4
`define DHPM_RED_MAX 10'd1000
`define DHPM_RED_DEF 10'd200
`define DHPM_PL_MAX 8'd250
`define DHPM_PL_DEF 8'd100
`define DHPM_PL_K200 10'd400
`define DHPM_PL_K400 10'd800
`define DHPM_FAN_DLY_MAX 9'd300
`define DHPM_FAN_DLY_DEF 9'd300
`define DHPM_AMB_MIN 6'd45
`define DHPM_AMB_MAX 6'd60
`define DHPM_AMB_DEF 6'd45
`define DHPM_HUNT_GAIN_MAX 8'd250
`define DHPM_HUNT_GAIN_DEF 8'd100
`define DHPM_DO_OH_PREALARM 8'h20
`define DHPM_LOW_SPEED_FREQ 16'd600
`define DHPM_SCLA_PCT 16'd110
`define DHPM_SCLA_STEP 16'd10
`define DHPM_OL2_BASE 24'd600000
`define DHPM_OL2_DERATE 24'd20000
`define DHPM_OL2_FAST_W 24'd4
`endif

// ---- verilog/dhpm_fan.v ----
// Purpose: Heatsink fan control with off-delay.
// Assumes: tick_s is a one-cycle pulse once per second.
// Notes: Delay is counted in whole seconds.
`timescale 1ns/10ps
`include "dhpm_consts.vh"
module dhpm_fan (
    // Clock and reset.
    input wire clk_sys,
    input wire sys_rst,
    // Control.
    input wire tick_s,
    input wire run,
    input wire fan_mode_sel,
    input wire [8:0] fan_off_delay,
    // Fan drive.
    output reg fan_on
);
    reg [8:0] remain;

    // A new run command reloads the delay, so a pending turn-off is cancelled.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            remain <= 9'h000;
            fan_on <= 1'b0;
        end else if (fan_mode_sel) begin
            fan_on <= 1'b1;
            remain <= 9'h000;
        end else if (run) begin
            fan_on <= 1'b1;
            remain <= fan_off_delay;
        end else if (remain == 9'h000) begin
            fan_on <= 1'b0;
        end else if (tick_s) begin
            remain <= remain - 9'h001;
        end
    end
endmodule // dhpm_fan

// ---- verilog/dhpm_ripple.v ----
// Purpose: DC bus ripple monitor for input phase loss.
// Assumes: tick_ms pulses once per millisecond; bus_valid marks new samples.
// Notes: Ten window results are summed, so the sum stands for ten times the mean.
`timescale 1ns/10ps
`include "dhpm_consts.vh"
module dhpm_ripple #(
    parameter START_MS = `DHPM_PL_START_MS,
    parameter WIN_MS = `DHPM_PL_WIN_MS
) (
    // Clock and reset.
    input wire clk_sys,
    input wire sys_rst,
    // Samples.
    input wire tick_ms,
    input wire bus_valid,
    input wire [11:0] bus_volt,
    // Trip level as ten times the mean ripple.
    input wire [17:0] trip_sum,
    // Result.
    output reg trip
);
    reg [13:0] start_cnt;
    reg started;
    reg [10:0] win_cnt;
    reg [11:0] vmin;
    reg [11:0] vmax;
    reg [3:0] scans;
    reg [15:0] sum;
    wire [15:0] next_sum = sum + {4'h0, vmax - vmin};

    // Wait for start-up, then close a window every WIN_MS milliseconds.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            start_cnt <= 14'h0000;
            started <= 1'b0;
            win_cnt <= 11'h000;
            vmin <= 12'hfff;
            vmax <= 12'h000;
            scans <= 4'h0;
            sum <= 16'h0000;
            trip <= 1'b0;
        end else begin
            trip <= 1'b0;
            if (!started) begin
                if (tick_ms) begin
                    start_cnt <= start_cnt + 14'h0001;
                    started <= (start_cnt == START_MS[13:0] - 14'h0001);
                end
            end else begin
                if (bus_valid && bus_volt < vmin) begin
                    vmin <= bus_volt;
                end
                if (bus_valid && bus_volt > vmax) begin
                    vmax <= bus_volt;
                end
                if (tick_ms && win_cnt == WIN_MS[10:0] - 11'h001) begin
                    win_cnt <= 11'h000;
                    vmin <= 12'hfff;
                    vmax <= 12'h000;
                    if (scans == `DHPM_PL_SCANS - 4'd1) begin
                        scans <= 4'h0;
                        sum <= 16'h0000;
                        trip <= ({2'b00, next_sum} > trip_sum);
                    end else begin
                        scans <= scans + 4'h1;
                        sum <= next_sum;
                    end
                end else if (tick_ms) begin
                    win_cnt <= win_cnt + 11'h001;
                end
            end
        end
    end
endmodule // dhpm_ripple

// ---- dv/dhpm_monitor.sv ----
// Purpose: Port checker for the protection supervisor.
// Assumes: Settings mirrored with the design's clamps.
// Notes: Bound to dhpm_top below the module.
`timescale 1ns/10ps
module dhpm_monitor (
    // Clock and reset.
    input wire clk_sys,
    input wire sys_rst,
    // Settings and measurements.
    input wire cfg_load,
    input wire braking_resistor_protect_sel,
    input wire [7:0] overheat_prealarm_level,
    input wire [2:0] overheat_action_sel,
    input wire fan_mode_sel,
    input wire [7:0] digital_output_function_sel,
    input wire [7:0] heatsink_temp_a,
    input wire [7:0] heatsink_temp_b,
    input wire [7:0] heatsink_temp_c,
    // Watched outputs.
    input wire ramp_stop_req,
    input wire coast_stop_req,
    input wire fast_stop_req,
    input wire heatsink_overheat_fault,
    input wire heatsink_overheat_alarm,
    input wire digital_output,
    input wire ground_fault_indication,
    input wire fan_on,
    input wire brake_sel_stored
);
// ********
// Setting mirror and properties
// ********
reg [19:0] s;
wire [7:0] lvl = s[19:12];
wire [7:0] dsel = s[11:4];
wire [2:0] act = s[3:1];
wire fm = s[0];
wire hot = (heatsink_temp_a > lvl) || (heatsink_temp_b > lvl) || (heatsink_temp_c > lvl);
wire [7:0] lin = (overheat_prealarm_level < 8'h32) ? 8'h32 :
    ((overheat_prealarm_level > 8'h82) ? 8'h82 : overheat_prealarm_level);
wire [2:0] ain = (overheat_action_sel > 3'h4) ? 3'h4 : overheat_action_sel;
// Outputs lag one cycle, so a load is mirrored on the same edge as the design takes it.
always @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
        s <= {8'h5f, 8'h00, 3'h4, 1'b0};
    end else if (cfg_load) begin
        s <= {lin, digital_output_function_sel, ain, fan_mode_sel};
    end
end
default clocking dcb @(posedge clk_sys);
endclocking
default disable iff (sys_rst);
a_do_hot: assert property (hot |=> digital_output == ($past(dsel) == 8'h20))
    else $error("prealarm output missing");
a_do_cool: assert property (!hot |=> !digital_output)
    else $error("prealarm output without heat");
a_alarm_mode: assert property (hot && act > 3'h2 |=> heatsink_overheat_alarm)
    else $error("overheat alarm missing");
a_ramp_sel: assert property (hot && act == 3'h0 |=> ramp_stop_req && heatsink_overheat_fault)
    else $error("ramp stop missing");
a_coast_sel: assert property (hot && act == 3'h1 |=> coast_stop_req)
    else $error("coast stop missing");
a_fast_sel: assert property (hot && act == 3'h2 |=> fast_stop_req)
    else $error("fast stop missing");
a_gf_coast: assert property ($rose(ground_fault_indication) |-> coast_stop_req)
    else $error("ground fault without coast");
a_fan_always: assert property (fm [*5] |-> fan_on)
    else $error("fan off in always-on mode");
a_brake_kept: assert property (cfg_load |=> brake_sel_stored == $past(braking_resistor_protect_sel))
    else $error("brake selection not stored");
c_reduce: cover property (hot && act == 3'h4);
c_gf: cover property ($rose(ground_fault_indication));
c_fan_off: cover property ($fell(fan_on));
endmodule // dhpm_monitor
bind dhpm_top dhpm_monitor u_mon (.*);

// ---- dv/dhpm_sensors.sv ----
// Purpose: Sensor side model: DC bus samples and phase currents.
// Assumes: The bench sets ripple and current levels between steps.
// Notes: The bus swings about a fixed mean, one sample every second cycle.
`timescale 1ns/10ps
module dhpm_sensors (
    // Clock and bench commands.
    input wire clk_sys,
    input wire [11:0] ripple,
    input wire signed [15:0] cur_pk,
    input wire signed [15:0] cur_gnd,
    // Measurements.
    output reg bus_valid = 1'b0,
    output reg [11:0] dc_bus_volt = 12'h400,
    output wire signed [15:0] phase_cur_u,
    output wire signed [15:0] phase_cur_v,
    output wire signed [15:0] phase_cur_w
);
// ********
// Model
// ********
reg hi = 1'b0;
// Samples alternate high and low, so each window sees the full ripple.
always @(posedge clk_sys) begin
    #1;
    bus_valid <= ~bus_valid;
    if (!bus_valid) begin
        hi <= ~hi;
        dc_bus_volt <= hi ? 12'h400 + ripple : 12'h400 - ripple;
    end
end
// Balanced phases plus an offset on one phase; the offset is the leak to ground.
assign phase_cur_u = cur_pk + cur_gnd;
assign phase_cur_v = -(cur_pk >>> 1);
assign phase_cur_w = -(cur_pk >>> 1);
endmodule // dhpm_sensors

// ---- dv/dhpm_top_tb.sv ----
// Purpose: Self-checking bench for the protection supervisor.
// Assumes: Short tick and phase-loss parameters; one second is 10000 cycles.
// Notes: Inputs change 1 ns after each rising edge.
`timescale 1ns/10ps
module dhpm_top_tb;
// ********
// Stimulus and checks
// ********
reg clk_sys = 1'b0, sys_rst = 1'b1, cfg_load = 1'b0, braking_resistor_protect_sel = 1'b0;
reg [7:0] overheat_prealarm_level = 8'h5f, phase_loss_level = 8'h01, antihunt_gain = 8'h64;
reg [2:0] overheat_action_sel = 3'h4;
reg [9:0] overheat_speed_reduction = 10'h0c8;
reg volt_class_400 = 1'b0, ground_fault_enable = 1'b1, fan_mode_sel = 1'b0, run_cmd = 1'b0;
reg low_speed_overload_sel = 1'b1, soft_current_limit_enable = 1'b1, antihunt_enable = 1'b1;
reg fault_reset = 1'b0;
reg [8:0] fan_off_delay = 9'h002;
reg [5:0] ambient_temp_setting = 6'h2d;
reg [7:0] digital_output_function_sel = 8'h00;
reg [23:0] temps = {3{8'h14}};
wire [7:0] heatsink_temp_a = temps[23:16], heatsink_temp_b = temps[15:8];
wire [7:0] heatsink_temp_c = temps[7:0];
reg [15:0] max_output_frequency = 16'h1770, rated_current = 16'h0096;
reg [15:0] output_frequency = 16'h0bb8, speed_command = 16'h1388;
reg signed [15:0] magnetising_current = 16'sh0000, cur_pk = 16'sh0000, cur_gnd = 16'sh0000;
reg [11:0] ripple = 12'h000;
wire ramp_stop_req, coast_stop_req, fast_stop_req, heatsink_overheat_fault, bus_valid;
wire heatsink_overheat_alarm, digital_output, software_current_limit, input_phase_loss_fault;
wire ground_fault_indication, drive_overload_fault, fan_on, brake_sel_stored;
wire [11:0] dc_bus_volt;
wire [15:0] speed_command_limited;
wire signed [15:0] voltage_trim, phase_cur_u, phase_cur_v, phase_cur_w;
wire [5:0] oh = {heatsink_overheat_fault, heatsink_overheat_alarm, ramp_stop_req,
    coast_stop_req, fast_stop_req, digital_output};
integer mismatches = 0, checks_done = 0, a, i;
dhpm_top #(.P_TICK_CYC(10), .P_PL_START_MS(20), .P_PL_WIN_MS(5)) dut (.*);
dhpm_sensors u_sensors (.*);
// Free-running 100 MHz clock.
initial begin
    forever #5 clk_sys = ~clk_sys;
end
task tick(input integer n);
    begin
        repeat (n) @(posedge clk_sys);
        #1;
    end
endtask
task chk(input [15:0] got, input [15:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    end
endtask
// The load pulse lasts one cycle; a gap cycle keeps two loads apart.
task cfg(input [7:0] l, input [2:0] act, input [2:0] f);
    begin
        overheat_prealarm_level = l;
        overheat_action_sel = act;
        {fan_mode_sel, ground_fault_enable, antihunt_enable} = f;
        braking_resistor_protect_sel = act[0];
        digital_output_function_sel = (act == 3'h2) ? 8'h00 : 8'h20;
        cfg_load = 1'b1;
        tick(1);
        cfg_load = 1'b0;
        tick(1);
    end
endtask
task finish_test;
    begin
        if (mismatches == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    end
endtask
// Main sequence.
initial begin
    tick(6);
    sys_rst = 1'b0;
    temps[23:16] = 8'h60;
    tick(2);
    chk(heatsink_overheat_alarm, 1'b1);
    temps[23:16] = 8'h5f;
    tick(2);
    chk(heatsink_overheat_alarm, 1'b0);
    for (a = 0; a < 5; a = a + 1) begin
        cfg(8'hc8, a[2:0], {1'b0, 1'b1, a != 1});
        chk(brake_sel_stored, a[0]);
        temps = {3{8'h82}};
        tick(2);
        chk(oh, 6'h00);
        temps = {3{8'h82}} + (24'h1 << (8 * (a % 3)));
        tick(2);
        chk(oh, {a < 3, a >= 3, a == 0, a == 1, a == 2, a != 2});
        if (a == 4) chk(speed_command_limited, 16'h0ed8);
        temps = {3{8'h14}};
        tick(2);
        chk(oh, {a < 3, 1'b0, a == 0, a == 1, a == 2, 1'b0});
        fault_reset = 1'b1;
        tick(2);
        fault_reset = 1'b0;
        chk(oh, 6'h00);
    end
    cur_gnd = 16'sd75;
    tick(3);
    chk(ground_fault_indication, 1'b0);
    cur_gnd = 16'sd76;
    tick(3);
    chk({ground_fault_indication, coast_stop_req}, 2'h3);
    cur_gnd = 16'sd0;
    fault_reset = 1'b1;
    tick(2);
    fault_reset = 1'b0;
    cfg(8'h5f, 3'h3, 3'b000);
    cur_gnd = 16'sd76;
    tick(3);
    chk(ground_fault_indication, 1'b0);
    cur_gnd = 16'sd0;
    cur_pk = 16'sd165;
    tick(3);
    chk(software_current_limit, 1'b0);
    cur_pk = 16'sd166;
    tick(3);
    chk(software_current_limit, 1'b1);
    cur_pk = 16'sd0;
    tick(3);
    chk(software_current_limit, 1'b0);
    tick(700);
    chk(input_phase_loss_fault, 1'b0);
    ripple = 12'h064;
    for (i = 0; i < 1500 && input_phase_loss_fault !== 1'b1; i = i + 1)
        tick(1);
    chk(input_phase_loss_fault, 1'b1);
    if (i == 1500) finish_test();
    cfg(8'h5f, 3'h3, 3'b010);
    chk(fan_on, 1'b0);
    run_cmd = 1'b1;
    tick(8);
    chk(fan_on, 1'b1);
    run_cmd = 1'b0;
    tick(5000);
    chk(fan_on, 1'b1);
    run_cmd = 1'b1;
    tick(8);
    run_cmd = 1'b0;
    tick(8000);
    chk(fan_on, 1'b1);
    for (i = 0; i < 14000 && fan_on !== 1'b0; i = i + 1)
        tick(1);
    chk(fan_on, 1'b0);
    if (i == 14000) finish_test();
    cfg(8'h5f, 3'h3, 3'b110);
    tick(6);
    chk(fan_on, 1'b1);
    finish_test();
end
endmodule // dhpm_top_tb
